// ---- logic/fsps_seq.sv ----
`timescale 1ns/1ps
`include "fsps_regs.svh"
// Summary of operation
// - command address comes from the 16-bit pointer, high and low halves
// - low pointer bits pick the word in a page, high bits pick the page
// - address is latched at start; later pointer changes do not matter
// - lock programming ignores the pointer
// - control 0x03 then store within four cycles erases the addressed page
// - control 0x01 then store loads data pair at word bits 5..1
// - buffer clears after page write, reenable write and reset; one write
// - an eeprom write during loading discards the loaded buffer
// - control 0x05 then store writes buffer into addressed page
// - rewritable target keeps other section readable; else cpu halts
// - interrupt enabled asserts continuously while enable bit is clear
// - erase or write blocks rewritable reads and holds busy flag
// - control 0x09 then store programs lock bits whose data bit is zero
// - lock programming keeps all flash readable, no cpu halt
// - enable and lock-set auto clear without store within four cycles
// - an eeprom write in progress blocks every programming command
// - each erase, write or lock operation lasts 3.7 to 4.5 ms
//
module fsps_seq
    import fsps_pkg::*;
#(
    parameter int WORD_BITS = 5,
    parameter int PAGE_BITS = 8,
    parameter int HALT_PAGE = 224,
    parameter int PROG_CYCLES = `FSPS_PROG_CYCLES
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    input  wire logic                 csr_wr,
    input  wire logic [7:0]           csr_wdata,
    output logic      [7:0]           self_prog_control_status,
    input  wire logic                 store_prog,
    input  wire logic [7:0]           address_pointer_high,
    input  wire logic [7:0]           address_pointer_low,
    input  wire logic [7:0]           data_high_reg,
    input  wire logic [7:0]           data_low_reg,
    input  wire logic                 eeprom_busy,
    input  wire logic                 eeprom_write,
    input  wire logic [WORD_BITS-1:0] buf_rd_word,
    output logic      [15:0]          buf_rd_data,
    output logic                      flash_erase,
    output logic                      flash_write,
    output logic      [PAGE_BITS-1:0] flash_page,
    output logic      [5:0]           lock_bits,
    output logic                      rewritable_blocked,
    output logic                      cpu_halt,
    output logic                      spm_irq
);
    import fsps_pkg::*;
    localparam int NW = 1 << WORD_BITS;

    typedef struct packed {
        fsps_state_t          st;
        fsps_op_t             op;
        logic [2:0]           arm;
        logic [4:0]           cmd;
        logic                 enable;
        logic                 lockset;
        logic                 ie;
        logic                 busy;
        logic                 halt;
        logic [PAGE_BITS-1:0] page;
        logic [5:0]           lock;
        logic [5:0]           lock_pend;
        logic [NW-1:0]        used;
    } fsps_state_s_t;
    fsps_state_s_t q_r;
    fsps_state_s_t q_nxt;

    logic [15:0] buf_mem [NW];
    logic [15:0] ptr;
    logic [PAGE_BITS-1:0] ptr_page;
    logic [WORD_BITS-1:0] ptr_word;
    logic        go;
    logic        do_load;
    logic        tmr_start;
    logic        tmr_done;

    ////////////////////////////////////////////////////////////////////////
    // pointer decode: word field is bits 5..1, page field above it
    assign ptr      = {address_pointer_high, address_pointer_low};
    assign ptr_word = ptr[WORD_BITS:1];
    assign ptr_page = ptr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
    // a store counts only inside the armed window and with no eeprom write
    assign go       = store_prog && q_r.st == FSPS_ARMED && !eeprom_busy;
    assign do_load  = go && q_r.cmd == `FSPS_CMD_LOAD && !q_r.used[ptr_word];
    assign tmr_start = go && (q_r.cmd == `FSPS_CMD_ERASE || q_r.cmd == `FSPS_CMD_WRITE
                              || q_r.cmd == `FSPS_CMD_LOCK);

    fsps_timer #(.CYCLES(PROG_CYCLES)) u_timer (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .start   (tmr_start),
        .done    (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        q_nxt = q_r;
        unique case (q_r.st)
            FSPS_IDLE: begin
                if (csr_wr && !eeprom_busy) begin
                    q_nxt.ie      = csr_wdata[`FSPS_CSR_IE_BIT];
                    q_nxt.cmd     = csr_wdata[4:0];
                    q_nxt.enable  = csr_wdata[`FSPS_CSR_ENABLE_BIT];
                    q_nxt.lockset = csr_wdata[`FSPS_CSR_LOCKSET_BIT];
                    q_nxt.arm     = `FSPS_ARM_CYCLES;
                    if (csr_wdata[`FSPS_CSR_ENABLE_BIT]) begin
                        q_nxt.st = FSPS_ARMED;
                    end
                end else if (csr_wr) begin
                    q_nxt.ie = csr_wdata[`FSPS_CSR_IE_BIT];
                end
            end
            FSPS_ARMED: begin
                if (go) begin
                    q_nxt.enable  = 1'b0;
                    q_nxt.lockset = 1'b0;
                    q_nxt.st      = FSPS_IDLE;
                    unique case (q_r.cmd)
                        `FSPS_CMD_ERASE, `FSPS_CMD_WRITE: begin
                            q_nxt.page   = ptr_page;
                            q_nxt.op     = (q_r.cmd == `FSPS_CMD_ERASE) ?
                                           FSPS_OP_ERASE : FSPS_OP_WRITE;
                            q_nxt.busy   = 1'b1;
                            q_nxt.halt   = ptr_page >= PAGE_BITS'(HALT_PAGE);
                            q_nxt.enable = 1'b1;
                            q_nxt.st     = FSPS_BUSY;
                        end
                        `FSPS_CMD_LOCK: begin
                            q_nxt.op        = FSPS_OP_LOCK;
                            q_nxt.lock_pend = data_low_reg[5:0];
                            q_nxt.enable    = 1'b1;
                            q_nxt.lockset   = 1'b1;
                            q_nxt.st        = FSPS_BUSY;
                        end
                        `FSPS_CMD_REENABLE: begin
                            q_nxt.busy = 1'b0;
                            q_nxt.used = '0;
                        end
                        `FSPS_CMD_LOAD: begin
                            if (do_load) begin
                                q_nxt.used[ptr_word] = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end else if (q_r.arm == 3'h1) begin
                    q_nxt.enable  = 1'b0;
                    q_nxt.lockset = 1'b0;
                    q_nxt.st      = FSPS_IDLE;
                end else begin
                    q_nxt.arm = q_r.arm - 3'h1;
                end
            end
            FSPS_BUSY: begin
                if (tmr_done) begin
                    q_nxt.enable  = 1'b0;
                    q_nxt.lockset = 1'b0;
                    q_nxt.halt    = 1'b0;
                    q_nxt.st      = FSPS_IDLE;
                    if (q_r.op == FSPS_OP_LOCK) begin
                        q_nxt.lock = q_r.lock & q_r.lock_pend;
                    end
                    if (q_r.op == FSPS_OP_WRITE) begin
                        q_nxt.used = '0;
                    end
                end
            end
        endcase
        // an eeprom write mid-load throws away the partly loaded buffer
        if (eeprom_write && q_r.st != FSPS_BUSY) begin
            q_nxt.used = '0;
            // a load landing in the same cycle keeps its word: the set wins
            if (do_load) begin
                q_nxt.used[ptr_word] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q_r           <= '0;
            q_r.st        <= FSPS_IDLE;
            q_r.op        <= FSPS_OP_ERASE;
            q_r.lock      <= `FSPS_LOCK_RESET;
            q_r.lock_pend <= `FSPS_LOCK_RESET;
        end else begin
            q_r <= q_nxt;
        end
    end

    // buffer data itself needs no reset; the used mask marks empty words
    always_ff @(posedge clk_sys) begin
        if (do_load) begin
            buf_mem[ptr_word] <= {data_high_reg, data_low_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; cleared buffer words read as erased flash
    assign buf_rd_data = q_r.used[buf_rd_word] ? buf_mem[buf_rd_word] : 16'hffff;
    assign flash_erase = q_r.st == FSPS_BUSY && q_r.op == FSPS_OP_ERASE;
    assign flash_write = q_r.st == FSPS_BUSY && q_r.op == FSPS_OP_WRITE;
    assign flash_page  = q_r.page;
    assign lock_bits   = q_r.lock;
    assign rewritable_blocked = q_r.busy;
    assign cpu_halt    = q_r.halt;
    assign spm_irq     = q_r.ie && !q_r.enable;
    assign self_prog_control_status = {q_r.ie, q_r.busy, 1'b0, 1'b0, q_r.lockset,
                                       q_r.cmd[2] & q_r.enable, q_r.cmd[1] & q_r.enable,
                                       q_r.enable};

    ////////////////////////////////////////////////////////////////////////
    sequence arm_seq;
        q_r.st == FSPS_IDLE && csr_wr && csr_wdata[0] && !eeprom_busy;
    endsequence
    sequence quiet4_seq;
        !store_prog [*4];
    endsequence
    property auto_clear_p;
        @(posedge clk_sys) disable iff (!rstn) arm_seq ##1 quiet4_seq |=> !q_r.enable;
    endproperty
    arm_timeout_a: assert property (auto_clear_p) else $error("enable not cleared");
    busy_block_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (flash_erase || flash_write) |-> rewritable_blocked) else $error("no block");
    // idle is the only state with the enable bit clear, so the irq follows it
    irq_level_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        spm_irq == (q_r.ie && q_r.st == FSPS_IDLE)) else $error("irq");
    op_enable_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        q_r.st == FSPS_BUSY |-> self_prog_control_status[0]) else $error("en");
    page_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (flash_erase && $past(flash_erase)) |-> $stable(flash_page)) else $error("pg");
    lock_nohalt_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (q_r.st == FSPS_BUSY && q_r.op == FSPS_OP_LOCK) |-> !cpu_halt) else $error("halt");
    eeprom_block_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (eeprom_busy && q_r.st != FSPS_BUSY) |=> !$rose(q_r.st == FSPS_BUSY)) else $error("ee");
    lock_mono_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        1'b1 |=> ((lock_bits & ~$past(lock_bits)) == 6'h00)) else $error("lock set");
    write_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (flash_write && tmr_done) |=> q_r.used == '0) else $error("buf");
endmodule : fsps_seq

// ---- logic/fsps_regs.svh ----
`ifndef FSPS_REGS_SVH
`define FSPS_REGS_SVH
// control/status bit positions
`define FSPS_CSR_ENABLE_BIT    0
`define FSPS_CSR_ERASE_BIT     1
`define FSPS_CSR_WRITE_BIT     2
`define FSPS_CSR_LOCKSET_BIT   3
`define FSPS_CSR_REENABLE_BIT  4
`define FSPS_CSR_BUSY_BIT      6
`define FSPS_CSR_IE_BIT        7
// command codes, low five bits of the control word
`define FSPS_CMD_LOAD          5'h01
`define FSPS_CMD_ERASE         5'h03
`define FSPS_CMD_WRITE         5'h05
`define FSPS_CMD_LOCK          5'h09
`define FSPS_CMD_REENABLE      5'h11
`define FSPS_CSR_RESET         8'h00
`define FSPS_LOCK_RESET        6'h3f
// store-program window after the control write, cpu cycles
`define FSPS_ARM_CYCLES        3'h4
// programming time in ns, min and max
`define FSPS_T_PROG_MIN_NS     3700000
`define FSPS_T_PROG_MAX_NS     4500000
`define FSPS_CLK_PERIOD_NS     25
`define FSPS_PROG_CYCLES       ((`FSPS_T_PROG_MIN_NS + `FSPS_CLK_PERIOD_NS - 1) / `FSPS_CLK_PERIOD_NS)
`endif

// ---- logic/fsps_pkg.sv ----
package fsps_pkg;
    typedef enum logic [1:0] {FSPS_IDLE, FSPS_ARMED, FSPS_BUSY} fsps_state_t;
    typedef enum logic [1:0] {FSPS_OP_ERASE, FSPS_OP_WRITE, FSPS_OP_LOCK} fsps_op_t;
endpackage : fsps_pkg

// ---- logic/fsps_timer.sv ----
`timescale 1ns/1ps
`include "fsps_regs.svh"
// counts one programming operation; done pulses once when it expires
module fsps_timer #(
    parameter int CYCLES = `FSPS_PROG_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic start,
    output logic      done
);
    typedef struct packed {
        logic [23:0] cnt;
        logic        run;
        logic        done;
    } fsps_tmr_t;
    fsps_tmr_t q_r;
    fsps_tmr_t q_nxt;

    // load on start, count down, pulse done at zero
    always_comb begin
        q_nxt      = q_r;
        q_nxt.done = 1'b0;
        if (start) begin
            q_nxt.cnt = 24'(CYCLES - 1);
            q_nxt.run = 1'b1;
        end else if (q_r.run) begin
            if (q_r.cnt == 24'h0) begin
                q_nxt.run  = 1'b0;
                q_nxt.done = 1'b1;
            end else begin
                q_nxt.cnt = q_r.cnt - 24'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign done = q_r.done;
endmodule : fsps_timer

// ---- dv/fsps_cpu_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// cpu side: writes the control byte, then issues the store gap edges later
module fsps_cpu_model (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       go,
    input  wire logic [7:0] code,
    input  wire logic [2:0] gap,
    output logic            csr_wr,
    output logic      [7:0] csr_wdata,
    output logic            store_prog
);
    logic [2:0] cnt_r;
    // gap 1..4 stays inside the store window, 0 skips the store, 5..7 is late
    // the data bus toggles outside a write so a stale byte is never mistaken for one
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            csr_wr     <= 1'b0;
            csr_wdata  <= 8'h00;
            cnt_r      <= 3'h0;
            store_prog <= 1'b0;
        end else begin
            csr_wr     <= go;
            csr_wdata  <= go ? code : ~csr_wdata;
            store_prog <= !go && (cnt_r == 3'h1);
            if (go) begin
                cnt_r <= gap;
            end else if (cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
            end
        end
    end
endmodule : fsps_cpu_model

// ---- dv/fsps_seq_tb_top.sv ----
`timescale 1ns/1ps
`define chk(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module fsps_seq_tb_top;
    localparam int PROG = 20; // shortened programming time
    typedef struct packed {logic [4:0] w; logic [15:0] d; logic [2:0] g;} fsps_row_t;
    fsps_row_t rows [3] = '{'{5'h00, 16'h1234, 3'h4}, '{5'h1f, 16'habcd, 3'h1},
                            '{5'h05, 16'h0f0f, 3'h2}};
    logic clk_sys = 1'b0, rstn = 1'b0, go = 1'b0, eeprom_busy = 1'b0, eeprom_write = 1'b0;
    logic [7:0] code = 8'h00, ph = 8'h00, pl = 8'h00, dh = 8'h00, dl = 8'h00, status;
    logic [2:0] gap = 3'h0;
    logic [4:0] rd_word = 5'h00;
    logic [15:0] buf_rd_data;
    logic [7:0] csr_wdata, flash_page;
    logic [5:0] lock_bits;
    logic csr_wr, store_prog, flash_erase, flash_write, rewritable_blocked, cpu_halt, spm_irq;
    int mismatches = 0, checks = 0, n;
    ////////////////////////////////////////////////////////////////////////////////
    fsps_cpu_model fsps_cpu_model_inst (.clk_sys(clk_sys), .rstn(rstn), .go(go), .code(code),
        .gap(gap), .csr_wr(csr_wr), .csr_wdata(csr_wdata), .store_prog(store_prog));
    fsps_seq #(.PROG_CYCLES(PROG)) fsps_seq_inst (.clk_sys(clk_sys), .rstn(rstn),
        .csr_wr(csr_wr), .csr_wdata(csr_wdata), .self_prog_control_status(status),
        .store_prog(store_prog), .address_pointer_high(ph), .address_pointer_low(pl),
        .data_high_reg(dh), .data_low_reg(dl), .eeprom_busy(eeprom_busy),
        .eeprom_write(eeprom_write), .buf_rd_word(rd_word), .buf_rd_data(buf_rd_data),
        .flash_erase(flash_erase), .flash_write(flash_write), .flash_page(flash_page),
        .lock_bits(lock_bits), .rewritable_blocked(rewritable_blocked),
        .cpu_halt(cpu_halt), .spm_irq(spm_irq));
    // 40 MHz
    always #12.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    // pointer and data settle before the control write and hold until the store
    task automatic cmd(input logic [7:0] c, input logic [2:0] g, input logic [7:0] h,
                       input logic [7:0] l, input logic [15:0] d);
        @(posedge clk_sys);
        ph <= h;
        pl <= l;
        {dh, dl} <= d;
        go <= 1'b1;
        code <= c;
        gap <= g;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (int'(g) + 3) @(posedge clk_sys);
        #1;
    endtask : cmd
    task automatic rd(input logic [4:0] w, input logic [15:0] e);
        @(posedge clk_sys);
        rd_word <= w;
        #1;
        `chk("buf_rd_data", e, buf_rd_data)
    endtask : rd
    // bounded wait for the enable bit to drop
    task automatic wait_op;
        n = 0;
        while (status[0] === 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 200) begin
            mismatches++;
            $display("[ERR] op_done exp 0 got 1");
            end_of_test();
        end
    endtask : wait_op
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        #1;
        `chk("status", 8'h00, status)
        `chk("lock_bits", 6'h3f, lock_bits)
        rd(5'h03, 16'hffff);
        $display("test reset done");
        // loads, buffer filled before the erase, high pointer byte ignored
        foreach (rows[i]) begin
            cmd(8'h01, rows[i].g, 8'h5a, {2'h0, rows[i].w, 1'b1}, rows[i].d);
            rd(rows[i].w, rows[i].d);
        end
        cmd(8'h01, 3'h2, 8'h00, 8'h0a, 16'h0000);
        rd(5'h05, 16'h0f0f);
        $display("test loads done");
        // erase page 7 with irq enabled; pointer moves during the op
        cmd(8'h83, 3'h2, 8'h01, 8'hc7, 16'h5555);
        `chk("flash_erase", 1'b1, flash_erase)
        `chk("flash_page", 8'h07, flash_page)
        `chk("rewritable_blocked", 1'b1, rewritable_blocked)
        `chk("cpu_halt", 1'b0, cpu_halt)
        `chk("spm_irq", 1'b0, spm_irq)
        `chk("status", 8'hc3, status)
        @(posedge clk_sys);
        ph <= 8'hff;
        #1;
        `chk("flash_page", 8'h07, flash_page)
        wait_op();
        `chk("op_len", 1'b1, (n >= PROG - 3 && n <= PROG + 3))
        `chk("flash_erase", 1'b0, flash_erase)
        `chk("spm_irq", 1'b1, spm_irq)
        `chk("rewritable_blocked", 1'b1, rewritable_blocked)
        cmd(8'h05, 3'h3, 8'h01, 8'hc0, 16'h0000);
        `chk("flash_write", 1'b1, flash_write)
        `chk("flash_page", 8'h07, flash_page)
        wait_op();
        rd(5'h1f, 16'hffff);
        cmd(8'h11, 3'h1, 8'h00, 8'h00, 16'h0000);
        `chk("rewritable_blocked", 1'b0, rewritable_blocked)
        $display("test erase write done");
        // page 224 sits in the halting section
        cmd(8'h05, 3'h4, 8'h38, 8'h00, 16'h0000);
        `chk("cpu_halt", 1'b1, cpu_halt)
        wait_op();
        cmd(8'h11, 3'h1, 8'h00, 8'h00, 16'h0000);
        // lock bits with a pointer that is not the suggested one
        // data bit 4 is zero, so the boot section gets locked
        cmd(8'h09, 3'h3, 8'hff, 8'hff, 16'h00c5);
        `chk("lock_set", 1'b1, status[3])
        `chk("cpu_halt", 1'b0, cpu_halt)
        `chk("rewritable_blocked", 1'b0, rewritable_blocked)
        wait_op();
        `chk("lock_bits", 6'h05, lock_bits)
        $display("test lock done");
        // store too late, then an undefined code, then eeprom busy
        cmd(8'h03, 3'h6, 8'h00, 8'h40, 16'h0000);
        `chk("status", 8'h00, status)
        `chk("flash_erase", 1'b0, flash_erase)
        cmd(8'h07, 3'h2, 8'h00, 8'h40, 16'h0000);
        `chk("flash_op", 1'b0, flash_erase | flash_write)
        `chk("lock_bits", 6'h05, lock_bits)
        @(posedge clk_sys);
        eeprom_busy <= 1'b1;
        cmd(8'h03, 3'h2, 8'h00, 8'h40, 16'h0000);
        `chk("flash_erase", 1'b0, flash_erase)
        `chk("status", 8'h00, status)
        @(posedge clk_sys);
        eeprom_busy <= 1'b0;
        cmd(8'h01, 3'h2, 8'h00, 8'h04, 16'h1111);
        rd(5'h02, 16'h1111);
        @(posedge clk_sys);
        eeprom_write <= 1'b1;
        @(posedge clk_sys);
        eeprom_write <= 1'b0;
        rd(5'h02, 16'hffff);
        $display("test refusals done");
        // a reset in mid-run throws away a loaded word
        cmd(8'h01, 3'h2, 8'h00, 8'h04, 16'h2222);
        rd(5'h02, 16'h2222);
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        #1;
        `chk("status", 8'h00, status)
        rd(5'h02, 16'hffff);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule : fsps_seq_tb_top
